// ==== bench/host_serial_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_serial_model
	import osc_align_pkg::*;
(
	// Three-wire bus
	output logic clk_link_o,
	output logic bus_enable_o,
	output logic bus_data_o
);
	initial begin
		clk_link_o = 1'b0;
		bus_enable_o = 1'b0;
		bus_data_o = 1'b1;
	end
	// Clock stands low outside frames and resets
	task automatic pulse();
		#32 clk_link_o = 1'b1;
		#32 clk_link_o = 1'b0;
	endtask
	task automatic idle_edges(input int n);
		repeat (n) pulse();
	endtask
	// LSB first; fewer than all bits makes an aborted frame
	task automatic send_frame(input logic [FRAME_BITS-1:0] f, input int n);
		#1.7;
		for (int i = 0; i < n; i++) begin
			bus_enable_o = 1'b1;
			bus_data_o = f[i];
			pulse();
		end
		bus_enable_o = 1'b0;
		bus_data_o = ~bus_data_o;
		pulse();
	endtask
endmodule // host_serial_model
`default_nettype wire

// ==== bench/osc_align_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module osc_align_ctrl_test;
	import osc_align_pkg::*;
	logic clk_sys, rst, cyc, stb, we;
	logic [7:0] adr;
	logic [31:0] wdat;
	wire logic [31:0] rdat;
	wire logic ack, clk_link, bus_en, bus_dat;
	osc_mode_s mode;
	conv_s conv1, conv2;
	int error_cnt, cmp_count;
	osc_align_ctrl i_osc_align_ctrl (.clk_sys_i(clk_sys), .rst_i(rst), .ce_i(1'b1),
		.clk_link_i(clk_link), .bus_enable_i(bus_en), .bus_data_i(bus_dat), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .osc_mode_o(mode), .first_alignment_converter_o(conv1),
		.second_alignment_converter_o(conv2));
	host_serial_model i_host_serial_model (.clk_link_o(clk_link), .bus_enable_o(bus_en),
		.bus_data_o(bus_dat));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Called right after a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (!w) check(rdat, wdat);
		if (n >= 20) begin
			error_cnt++;
			give_verdict();
		end else begin
			cyc <= 1'b0;
			stb <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	function automatic osc_mode_s exp_mode(input logic [FRAME_BITS-1:0] f);
		return f[OSC_ENABLE_BIT] ? {2'b10 | f[BUFFER_DIRECTION_BIT], 2'b00} : 4'b0011;
	endfunction
	function automatic logic [31:0] exp_conv(input logic [FRAME_BITS-1:0] f, input int g,
		input int o);
		return {17'h0, f[o +: OFFS_W], f[g +: GAIN_W]};
	endfunction
	// Converter outputs carry gain above offset, unlike the register view
	function automatic conv_s exp_code(input logic [FRAME_BITS-1:0] f, input int g,
		input int o);
		return '{gain: f[g +: GAIN_W], offset: f[o +: OFFS_W]};
	endfunction
	initial begin
		logic [FRAME_BITS-1:0] f, last;
		rst = 1'b1;
		{cyc, stb, we, adr, wdat} = '0;
		error_cnt = 0;
		cmp_count = 0;
		last = FRAME_BITS'($urandom(32'h1ae3828a));
		i_host_serial_model.idle_edges(4);
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check(32'(mode), {28'h0, OSC_ENABLE_RST, BUFFER_DIRECTION_RST, 2'b00});
		check(32'(conv1), 32'(CONV_RST));
		check(32'(conv2), 32'(CONV_RST));
		wb(1'b0, MODE_ADR, {30'h0, OSC_ENABLE_RST, BUFFER_DIRECTION_RST});
		wb(1'b0, 8'h40, 32'h0);
		// Link reset only leaves its synchroniser on link clock edges
		i_host_serial_model.idle_edges(3);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			f = FRAME_BITS'({$urandom, $urandom, $urandom, $urandom, $urandom});
			if (k < 3) begin
				f[OSC_ENABLE_BIT] = (k != 0);
				f[BUFFER_DIRECTION_BIT] = (k != 1);
				f[CONV1_GAIN_LSB +: GAIN_W] = {GAIN_W{k[0]}};
				f[CONV2_GAIN_LSB +: GAIN_W] = {GAIN_W{k[0]}};
				f[CONV1_OFFS_LSB +: OFFS_W] = {OFFS_W{~k[0]}};
				f[CONV2_OFFS_LSB +: OFFS_W] = {OFFS_W{~k[0]}};
			end
			i_host_serial_model.send_frame(f, FRAME_BITS);
			@(posedge clk_sys);
			check(32'(mode), 32'(exp_mode(f)));
			check(32'(conv1),
				32'(exp_code(f, CONV1_GAIN_LSB, CONV1_OFFS_LSB)));
			check(32'(conv2),
				32'(exp_code(f, CONV2_GAIN_LSB, CONV2_OFFS_LSB)));
			wb(1'b0, MODE_ADR, {30'h0, f[OSC_ENABLE_BIT], f[BUFFER_DIRECTION_BIT]});
			wb(1'b0, CONV2_ADR, exp_conv(f, CONV2_GAIN_LSB, CONV2_OFFS_LSB));
			wb(1'b0, FRAMES_ADR, 32'(k + 1));
			last = f;
		end
		$display("test frames done");
		for (int n = 145; n > 0; n -= 144) begin
			i_host_serial_model.send_frame(~last, n);
			@(posedge clk_sys);
			check(32'(mode), 32'(exp_mode(last)));
			check(32'(conv1),
				32'(exp_code(last, CONV1_GAIN_LSB, CONV1_OFFS_LSB)));
		end
		wb(1'b0, ABORTS_ADR, 32'h2);
		wb(1'b0, STATUS_ADR, 32'h3);
		wb(1'b1, STATUS_ADR, 32'h2);
		wb(1'b0, STATUS_ADR, 32'h1);
		wb(1'b1, MODE_ADR, 32'h0);
		wb(1'b0, MODE_ADR, {30'h0, last[OSC_ENABLE_BIT], last[BUFFER_DIRECTION_BIT]});
		wb(1'b1, CTRL_ADR, 32'h3);
		wb(1'b0, CTRL_ADR, 32'h1);
		wb(1'b0, FRAMES_ADR, 32'h0);
		check(32'(conv2),
			32'(exp_code(last, CONV2_GAIN_LSB, CONV2_OFFS_LSB)));
		$display("test abort done");
		// Frozen settings: a complete frame is counted but not applied
		f = FRAME_BITS'({$urandom, $urandom, $urandom, $urandom, $urandom});
		f[OSC_ENABLE_BIT] = ~last[OSC_ENABLE_BIT];
		wb(1'b1, CTRL_ADR, 32'h0);
		i_host_serial_model.send_frame(f, FRAME_BITS);
		@(posedge clk_sys);
		check(32'(mode), 32'(exp_mode(last)));
		check(32'(conv1),
			32'(exp_code(last, CONV1_GAIN_LSB, CONV1_OFFS_LSB)));
		wb(1'b0, FRAMES_ADR, 32'h1);
		wb(1'b0, CTRL_ADR, 32'h0);
		wb(1'b1, CTRL_ADR, 32'h1);
		$display("test freeze done");
		give_verdict();
	end
endmodule // osc_align_ctrl_test
`default_nettype wire

// ==== bench/osc_align_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module osc_align_chk
	import osc_align_pkg::*;
(
	// System
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Link
	input wire logic clk_link_i,
	input wire logic bus_enable_i,
	input wire logic bus_data_i,
	// Register bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [osc_align_pkg::ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Settings
	input wire osc_align_pkg::osc_mode_s osc_mode_o,
	input wire osc_align_pkg::conv_s first_alignment_converter_o,
	input wire osc_align_pkg::conv_s second_alignment_converter_o
);
	// ----
	// Idle window
	// ----
	// Enable sampled raw: only a coarse window is needed here
	logic [4:0] idle_r;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || bus_enable_i) begin
			idle_r <= 5'h00;
		end else if (idle_r != 5'h1f) begin
			idle_r <= idle_r + 5'h01;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ----
	// Assertions
	// ----
	a_osc_off_mode: assert property (!osc_mode_o.osc_on |->
		osc_mode_o.buf_input && osc_mode_o.lf_ext_tune && !osc_mode_o.buf_drive)
		else $error("oscillator off mode wrong");
	a_osc_on_mode: assert property (osc_mode_o.osc_on |->
		!osc_mode_o.buf_input && !osc_mode_o.lf_ext_tune) else $error("standard mode wrong");
	a_buf_dir_read: assert property (ack_o && $past(!we_i && adr_i == MODE_ADR &&
		osc_mode_o.osc_on) |-> dat_o[1:0] == {1'b1, $past(osc_mode_o.buf_drive)})
		else $error("buffer drive mismatch");
	a_conv1_read: assert property (ack_o && $past(!we_i && adr_i == CONV1_ADR) |->
		dat_o[14:0] == {$past(first_alignment_converter_o.offset),
		$past(first_alignment_converter_o.gain)}) else $error("first converter mismatch");
	a_conv2_read: assert property (ack_o && $past(!we_i && adr_i == CONV2_ADR) |->
		dat_o[14:0] == {$past(second_alignment_converter_o.offset),
		$past(second_alignment_converter_o.gain)}) else $error("second converter mismatch");
	a_hold_settings: assert property ($changed({osc_mode_o, first_alignment_converter_o,
		second_alignment_converter_o}) |-> idle_r < 5'h04) else $error("settings moved idle");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
		else $error("no answer");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0) else $error("data not zero");
endmodule // osc_align_chk
bind osc_align_ctrl osc_align_chk i_chk (.clk_sys_i, .rst_i, .ce_i, .clk_link_i, .bus_enable_i,
	.bus_data_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .osc_mode_o,
	.first_alignment_converter_o, .second_alignment_converter_o);
`default_nettype wire

// ==== core/bit_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
	parameter int W = 1
) (
	// Destination clock
	input wire logic clk_i,
	// Level from another domain
	input wire logic [W-1:0] d_i,
	// Synchronised level
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		meta_r <= d_i;
		q_o <= meta_r;
	end

endmodule // bit_sync

`default_nettype wire

// ==== core/osc_align_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module osc_align_ctrl
	import osc_align_pkg::*;
(
	// System clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Three-wire bus
	input wire logic clk_link_i,
	input wire logic bus_enable_i,
	input wire logic bus_data_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [osc_align_pkg::ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Oscillator and loop filter pin control
	output osc_align_pkg::osc_mode_s osc_mode_o,
	// Alignment converter codes
	output osc_align_pkg::conv_s first_alignment_converter_o,
	output osc_align_pkg::conv_s second_alignment_converter_o
);

	import osc_align_pkg::*;

	// ----------------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------------
	logic link_rst;
	logic [FRAME_BITS-1:0] frame_link;
	logic done_tgl_link;
	logic abort_tgl_link;

	// Reset reaches the link side only while its clock runs
	bit_sync #(.W(1)) u_link_rst (
		.clk_i(clk_link_i),
		.d_i(rst_i),
		.q_o(link_rst)
	);

	serial_frame_rx u_rx (
		.clk_link_i(clk_link_i),
		.rst_i(link_rst),
		.bus_enable_i(bus_enable_i),
		.bus_data_i(bus_data_i),
		.frame_o(frame_link),
		.done_tgl_o(done_tgl_link),
		.abort_tgl_o(abort_tgl_link)
	);

	// ----------------------------------------------------------------
	// Crossing into the system domain
	// ----------------------------------------------------------------
	logic [1:0] tgl_sync;
	logic [1:0] tgl_prev_r;

	bit_sync #(.W(2)) u_tgl_sync (
		.clk_i(clk_sys_i),
		.d_i({abort_tgl_link, done_tgl_link}),
		.q_o(tgl_sync)
	);

	wire logic frame_evt = tgl_sync[0] ^ tgl_prev_r[0];
	wire logic abort_evt = tgl_sync[1] ^ tgl_prev_r[1];

	// frame_link is stable for a whole frame after its toggle
	wire logic osc_bit = frame_link[OSC_ENABLE_BIT];
	wire logic dir_bit = frame_link[BUFFER_DIRECTION_BIT];
	wire logic [GAIN_W-1:0] gain1_bits = frame_link[CONV1_GAIN_LSB +: GAIN_W];
	wire logic [GAIN_W-1:0] gain2_bits = frame_link[CONV2_GAIN_LSB +: GAIN_W];
	wire logic [OFFS_W-1:0] offs1_bits = frame_link[CONV1_OFFS_LSB +: OFFS_W];
	wire logic [OFFS_W-1:0] offs2_bits = frame_link[CONV2_OFFS_LSB +: OFFS_W];

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic osc_bit_r;
	logic dir_bit_r;
	conv_s conv1_r;
	conv_s conv2_r;
	osc_mode_s mode_nxt;

	always_comb begin
		mode_nxt.osc_on = osc_bit;
		mode_nxt.lf_ext_tune = !osc_bit;
		mode_nxt.buf_input = !osc_bit;
		// Direction bit only counts with the oscillator running
		mode_nxt.buf_drive = osc_bit && dir_bit;
	end

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	logic ctrl_apply_r;
	logic stat_frame_r;
	logic stat_abort_r;
	logic [EVT_CNT_W-1:0] frames_r;
	logic [EVT_CNT_W-1:0] aborts_r;
	logic [31:0] rd_mux;

	wire logic bus_req = cyc_i && stb_i && !ack_o;
	wire logic wr_req = bus_req && we_i;
	wire logic wr_ctrl = wr_req && adr_i == CTRL_ADR && sel_i[0];
	wire logic wr_stat = wr_req && adr_i == STATUS_ADR && sel_i[0];
	wire logic clr_cnt = wr_ctrl && dat_i[CTRL_CLR_CNT_POS];
	wire logic clr_frame = wr_stat && dat_i[STAT_FRAME_POS];
	wire logic clr_abort = wr_stat && dat_i[STAT_ABORT_POS];
	// Software may freeze the active settings while still counting frames
	wire logic apply = frame_evt && ctrl_apply_r;

	wire logic [31:0] rd_ctrl = {31'h0, ctrl_apply_r};
	wire logic [31:0] rd_stat = {30'h0, stat_abort_r, stat_frame_r};
	wire logic [31:0] rd_mode = {30'h0, osc_bit_r, dir_bit_r};
	wire logic [31:0] rd_conv1 = {17'h0, conv1_r.offset, conv1_r.gain};
	wire logic [31:0] rd_conv2 = {17'h0, conv2_r.offset, conv2_r.gain};
	wire logic [31:0] rd_frames = {16'h0, frames_r};
	wire logic [31:0] rd_aborts = {16'h0, aborts_r};

	// Unmapped addresses still answer, with zero
	always_comb begin
		case (adr_i)
			CTRL_ADR: rd_mux = rd_ctrl;
			STATUS_ADR: rd_mux = rd_stat;
			MODE_ADR: rd_mux = rd_mode;
			CONV1_ADR: rd_mux = rd_conv1;
			CONV2_ADR: rd_mux = rd_conv2;
			FRAMES_ADR: rd_mux = rd_frames;
			ABORTS_ADR: rd_mux = rd_aborts;
			default: rd_mux = 32'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else if (ce_i) begin
			ack_o <= bus_req;
			dat_o <= bus_req ? rd_mux : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Control and event bookkeeping
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tgl_prev_r <= 2'h0;
			ctrl_apply_r <= CTRL_APPLY_RST;
			stat_frame_r <= 1'b0;
			stat_abort_r <= 1'b0;
		end else if (ce_i) begin
			tgl_prev_r <= tgl_sync;
			if (wr_ctrl) begin
				ctrl_apply_r <= dat_i[CTRL_APPLY_POS];
			end
			// A new event beats a clear in the same cycle
			stat_frame_r <= frame_evt || (stat_frame_r && !clr_frame);
			stat_abort_r <= abort_evt || (stat_abort_r && !clr_abort);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			frames_r <= '0;
			aborts_r <= '0;
		end else if (ce_i) begin
			if (frame_evt) begin
				frames_r <= clr_cnt ? 16'h0001 : frames_r + 16'h0001;
			end else if (clr_cnt) begin
				frames_r <= '0;
			end
			if (abort_evt) begin
				aborts_r <= clr_cnt ? 16'h0001 : aborts_r + 16'h0001;
			end else if (clr_cnt) begin
				aborts_r <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Active settings
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			osc_bit_r <= OSC_ENABLE_RST;
			dir_bit_r <= BUFFER_DIRECTION_RST;
			osc_mode_o <= '{osc_on: OSC_ENABLE_RST, buf_drive: 1'b0,
				buf_input: 1'b0, lf_ext_tune: 1'b0};
			conv1_r <= CONV_RST;
			conv2_r <= CONV_RST;
		end else if (ce_i && apply) begin
			osc_bit_r <= osc_bit;
			dir_bit_r <= dir_bit;
			osc_mode_o <= mode_nxt;
			conv1_r <= '{gain: gain1_bits, offset: offs1_bits};
			conv2_r <= '{gain: gain2_bits, offset: offs2_bits};
		end
	end

	// Code passes through unchanged: 0 is least gain, most positive offset
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			first_alignment_converter_o <= CONV_RST;
			second_alignment_converter_o <= CONV_RST;
		end else if (ce_i && apply) begin
			first_alignment_converter_o <= '{gain: gain1_bits, offset: offs1_bits};
			second_alignment_converter_o <= '{gain: gain2_bits, offset: offs2_bits};
		end
	end

endmodule // osc_align_ctrl

`default_nettype wire

// ==== core/osc_align_pkg.sv ====
package osc_align_pkg;

	// ----------------------------------------------------------------
	// Serial frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 146;
	localparam logic [7:0] FRAME_LEN = 8'h92;
	localparam int CNT_W = 8;

	localparam int OSC_ENABLE_BIT = 65;
	localparam int BUFFER_DIRECTION_BIT = 64;
	localparam int CONV1_GAIN_LSB = 38;
	localparam int CONV2_GAIN_LSB = 66;
	localparam int CONV1_OFFS_LSB = 24;
	localparam int CONV2_OFFS_LSB = 52;
	localparam int GAIN_W = 8;
	localparam int OFFS_W = 7;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [7:0] CTRL_ADR = 8'h00;
	localparam logic [7:0] STATUS_ADR = 8'h04;
	localparam logic [7:0] MODE_ADR = 8'h08;
	localparam logic [7:0] CONV1_ADR = 8'h0c;
	localparam logic [7:0] CONV2_ADR = 8'h10;
	localparam logic [7:0] FRAMES_ADR = 8'h14;
	localparam logic [7:0] ABORTS_ADR = 8'h18;

	// CTRL fields
	localparam int CTRL_APPLY_POS = 0;
	localparam int CTRL_CLR_CNT_POS = 1;
	localparam logic CTRL_APPLY_RST = 1'b1;

	// STATUS fields, write one to clear
	localparam int STAT_FRAME_POS = 0;
	localparam int STAT_ABORT_POS = 1;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic OSC_ENABLE_RST = 1'b1;
	localparam logic BUFFER_DIRECTION_RST = 1'b0;
	localparam logic [7:0] GAIN_RST = 8'h3a;
	localparam logic [6:0] OFFS_RST = 7'h40;
	localparam int EVT_CNT_W = 16;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic [OFFS_W-1:0] offset;
	} conv_s;

	typedef struct packed {
		logic osc_on;
		logic buf_drive;
		logic buf_input;
		logic lf_ext_tune;
	} osc_mode_s;

	localparam conv_s CONV_RST = '{gain: GAIN_RST, offset: OFFS_RST};

endpackage

// ==== core/serial_frame_rx.sv ====
`timescale 1ns/1ps
`default_nettype none

module serial_frame_rx
	import osc_align_pkg::*;
(
	// Link clock and reset
	input wire logic clk_link_i,
	input wire logic rst_i,
	// Three-wire bus
	input wire logic bus_enable_i,
	input wire logic bus_data_i,
	// Frame toward the system domain
	output logic [FRAME_BITS-1:0] frame_o,
	output logic done_tgl_o,
	output logic abort_tgl_o
);

	logic [FRAME_BITS-1:0] shift_r;
	logic [CNT_W-1:0] count_r;
	logic en_q_r;
	wire logic [FRAME_BITS-1:0] shift_nxt = {bus_data_i, shift_r[FRAME_BITS-1:1]};
	wire logic last_bit = (count_r == FRAME_LEN - 8'h01);
	wire logic full = (count_r == FRAME_LEN);

	// ----------------------------------------------------------------
	// Shift, count, hand over complete frames
	// ----------------------------------------------------------------
	// Bit 0 is sent first; bits past the frame length are ignored
	always_ff @(posedge clk_link_i) begin
		if (rst_i) begin
			count_r <= '0;
			en_q_r <= 1'b0;
			done_tgl_o <= 1'b0;
			abort_tgl_o <= 1'b0;
		end else begin
			en_q_r <= bus_enable_i;
			if (bus_enable_i && !full) begin
				shift_r <= shift_nxt;
				count_r <= count_r + 8'h01;
				if (last_bit) begin
					frame_o <= shift_nxt;
					done_tgl_o <= ~done_tgl_o;
				end
			end else if (!bus_enable_i) begin
				// Short frame never reaches frame_o
				if (en_q_r && count_r != '0 && !full) begin
					abort_tgl_o <= ~abort_tgl_o;
				end
				count_r <= '0;
			end
		end
	end

endmodule // serial_frame_rx

`default_nettype wire
